// ### include/ndr_pkg.sv
// Purpose: Constants and state type for the network controller DMA, filter and tally register bank
// Assumes: 32-bit Avalon-MM data, one 8-bit register per aligned word
// Notes:   Register byte address is four times the register index
package ndr_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_TX_LEN_LO     = 6'h00;
  localparam logic [5:0] IDX_TX_LEN_HI     = 6'h01;
  localparam logic [5:0] IDX_RING_FIRST    = 6'h02;
  localparam logic [5:0] IDX_RING_LAST     = 6'h03;
  localparam logic [5:0] IDX_RING_GUARD    = 6'h04;
  localparam logic [5:0] IDX_RX_WRITE_PAGE = 6'h05;
  localparam logic [5:0] IDX_LDA_LO        = 6'h06;
  localparam logic [5:0] IDX_LDA_HI        = 6'h07;
  localparam logic [5:0] IDX_COPY_START_LO = 6'h08;
  localparam logic [5:0] IDX_COPY_START_HI = 6'h09;
  localparam logic [5:0] IDX_COPY_COUNT_LO = 6'h0A;
  localparam logic [5:0] IDX_COPY_COUNT_HI = 6'h0B;
  localparam logic [5:0] IDX_COPY_ADDR_LO  = 6'h0C;
  localparam logic [5:0] IDX_COPY_ADDR_HI  = 6'h0D;
  localparam logic [5:0] IDX_STATION_BASE  = 6'h0E;
  localparam logic [5:0] IDX_HASH_BASE     = 6'h14;
  localparam logic [5:0] IDX_TALLY_BASE    = 6'h1C;
  localparam logic [5:0] IDX_LOOPBACK_PORT = 6'h1F;
  localparam logic [5:0] IDX_LAST          = 6'h1F;

  // ----------------------------------------------------------------
  // Counts, reset values and hash constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  TALLY_MAX        = 8'hC0;
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [15:0] RST_WORD         = 16'h0000;
  localparam logic [2:0]  DA_LAST_BYTE     = 3'h5;
  localparam logic [31:0] CRC_INIT         = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY         = 32'h04C1_1DB7;
  localparam int          TALLY_ALIGN      = 0;
  localparam int          TALLY_CRC        = 1;
  localparam int          TALLY_LOST       = 2;

  // All state of the register bank
  typedef struct packed {
    logic             ack;
    logic [31:0]      rdata;
    logic [15:0]      tx_len;
    logic [7:0]       ring_first;
    logic [7:0]       ring_last;
    logic [7:0]       ring_guard;
    logic [7:0]       wpage;
    logic [15:0]      lda;
    logic             abort;
    logic [15:0]      copy_start;
    logic [15:0]      copy_count;
    logic [15:0]      copy_addr;
    logic [5:0][7:0]  station;
    logic [7:0][7:0]  hash;
    logic [2:0][7:0]  tally;
    logic [7:0][7:0]  lb_mem;
    logic [2:0]       lb_wr;
    logic [2:0]       lb_rd;
    logic [2:0]       da_idx;
    logic             da_done;
    logic             phys_ok;
    logic             group;
    logic [31:0]      crc;
    logic [5:0]       hash_idx;
  } ndr_state_t;

endpackage

// ### src/ndr_regs.sv
// Purpose: DMA pointer, address filter, tally and loopback register bank on an Avalon-MM slave
// Assumes: All event inputs come from logic on clk_sys_i; one-cycle pulses unless stated
// Notes:   Each access waits one cycle; side effects of a read land at its accepting edge
`timescale 1ns/100ps

module ndr_regs (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic      [15:0] tx_length_o,
  input  wire logic        rx_start_i,
  input  wire logic        rx_da_valid_i,
  input  wire logic [7:0]  rx_da_byte_i,
  input  wire logic        rx_byte_i,
  input  wire logic        frame_end_i,
  input  wire logic        fae_i,
  input  wire logic        crc_err_i,
  input  wire logic        no_buffer_i,
  input  wire logic        listen_only_mode_i,
  input  wire logic        loopback_mode_i,
  input  wire logic        lb_valid_i,
  input  wire logic [7:0]  lb_byte_i,
  input  wire logic        copy_step_i,
  input  wire logic        copy_word_i,
  output logic      [15:0] local_dma_addr_o,
  output logic             ring_abort_o,
  output logic      [15:0] host_copy_addr_o,
  output logic      [15:0] host_copy_count_o,
  output logic             copy_done_o,
  output logic             addr_match_o,
  output logic             group_indicator_bit_o,
  output logic             rx_store_o
);

  // ----------------------------------------------------------------
  // Serial CRC over one byte, first bit on the wire is bit 0
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] v;
    v = c;
    for (int i = 0; i < 8; i++) begin
      v = (v[31] ^ d[i]) ? ({v[30:0], 1'b0} ^ ndr_pkg::CRC_POLY) : {v[30:0], 1'b0};
    end
    return v;
  endfunction

  ndr_pkg::ndr_state_t r;
  ndr_pkg::ndr_state_t n;

  logic        req;
  logic        take;
  logic        wr_take;
  logic        rd_take;
  logic [5:0]  idx;
  logic        mapped;
  logic [7:0]  wbyte;
  logic [7:0]  next_pg;
  logic [7:0]  done_pg;
  logic        recognised;
  logic        hash_hit;
  logic [2:0]  tally_inc;
  logic        rx_err;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One wait cycle per access lets read data come from a flop
  assign req     = avs_read_i | avs_write_i;
  assign take    = req & r.ack;
  assign wr_take = take & avs_write_i & avs_byteenable_i[0];
  assign rd_take = take & avs_read_i;
  assign idx     = avs_address_i[7:2];
  assign mapped  = (idx <= ndr_pkg::IDX_LAST);
  assign wbyte   = avs_writedata_i[7:0];

  // Ring page stepping, wrapping to ring_first instead of entering ring_last
  assign next_pg = (r.lda[15:8] + 8'h01 == r.ring_last) ? r.ring_first : r.lda[15:8] + 8'h01;
  assign done_pg = next_pg;

  // Address recognition from station bytes and group hash
  assign hash_hit   = r.hash[r.hash_idx[5:3]][r.hash_idx[2:0]];
  assign recognised = r.da_done & (r.group ? hash_hit : r.phys_ok);
  assign rx_err     = fae_i | crc_err_i | no_buffer_i;

  // Tally events, error counts gated by address recognition
  assign tally_inc[ndr_pkg::TALLY_ALIGN] = frame_end_i & recognised & fae_i;
  assign tally_inc[ndr_pkg::TALLY_CRC]   = frame_end_i & recognised & crc_err_i;
  assign tally_inc[ndr_pkg::TALLY_LOST]  = frame_end_i & recognised &
                                           (listen_only_mode_i | no_buffer_i);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n       = r;
    n.ack   = req & ~r.ack;
    n.abort = 1'b0;

    // Snapshot read data when the request is first seen
    if (req & ~r.ack & avs_read_i) begin
      n.rdata = 32'h0000_0000;
      case (idx)
        ndr_pkg::IDX_RING_FIRST:    n.rdata[7:0] = r.ring_first;
        ndr_pkg::IDX_RING_LAST:     n.rdata[7:0] = r.ring_last;
        ndr_pkg::IDX_RING_GUARD:    n.rdata[7:0] = r.ring_guard;
        ndr_pkg::IDX_RX_WRITE_PAGE: n.rdata[7:0] = r.wpage;
        ndr_pkg::IDX_LDA_LO:        n.rdata[7:0] = r.lda[7:0];
        ndr_pkg::IDX_LDA_HI:        n.rdata[7:0] = r.lda[15:8];
        ndr_pkg::IDX_COPY_ADDR_LO:  n.rdata[7:0] = r.copy_addr[7:0];
        ndr_pkg::IDX_COPY_ADDR_HI:  n.rdata[7:0] = r.copy_addr[15:8];
        ndr_pkg::IDX_LOOPBACK_PORT: n.rdata[7:0] = r.lb_mem[r.lb_rd];
        default: begin
          if (idx >= ndr_pkg::IDX_STATION_BASE && idx < ndr_pkg::IDX_HASH_BASE) begin
            n.rdata[7:0] = r.station[3'(idx - ndr_pkg::IDX_STATION_BASE)];
          end else if (idx >= ndr_pkg::IDX_HASH_BASE && idx < ndr_pkg::IDX_TALLY_BASE) begin
            n.rdata[7:0] = r.hash[3'(idx - ndr_pkg::IDX_HASH_BASE)];
          end else if (idx >= ndr_pkg::IDX_TALLY_BASE && idx < ndr_pkg::IDX_LOOPBACK_PORT) begin
            n.rdata[7:0] = r.tally[2'(idx - ndr_pkg::IDX_TALLY_BASE)];
          end
        end
      endcase
    end

    // Register writes; write-only and unmapped words are dropped on read side
    if (wr_take & mapped) begin
      case (idx)
        ndr_pkg::IDX_TX_LEN_LO:     n.tx_len[7:0]      = wbyte;
        ndr_pkg::IDX_TX_LEN_HI:     n.tx_len[15:8]     = wbyte;
        ndr_pkg::IDX_RING_FIRST:    n.ring_first       = wbyte;
        ndr_pkg::IDX_RING_LAST:     n.ring_last        = wbyte;
        ndr_pkg::IDX_RING_GUARD:    n.ring_guard       = wbyte;
        ndr_pkg::IDX_RX_WRITE_PAGE: n.wpage            = wbyte;
        ndr_pkg::IDX_COPY_START_LO: begin
          n.copy_start[7:0] = wbyte;
          n.copy_addr[7:0]  = wbyte;
        end
        ndr_pkg::IDX_COPY_START_HI: begin
          n.copy_start[15:8] = wbyte;
          n.copy_addr[15:8]  = wbyte;
        end
        ndr_pkg::IDX_COPY_COUNT_LO: n.copy_count[7:0]  = wbyte;
        ndr_pkg::IDX_COPY_COUNT_HI: n.copy_count[15:8] = wbyte;
        default: begin
          if (idx >= ndr_pkg::IDX_STATION_BASE && idx < ndr_pkg::IDX_HASH_BASE) begin
            n.station[3'(idx - ndr_pkg::IDX_STATION_BASE)] = wbyte;
          end else if (idx >= ndr_pkg::IDX_HASH_BASE && idx < ndr_pkg::IDX_TALLY_BASE) begin
            n.hash[3'(idx - ndr_pkg::IDX_HASH_BASE)] = wbyte;
          end
        end
      endcase
    end

    // Copy channel stepping by byte or word
    if (copy_step_i) begin
      n.copy_addr  = r.copy_addr + (copy_word_i ? 16'h0002 : 16'h0001);
      n.copy_count = (r.copy_count < (copy_word_i ? 16'h0002 : 16'h0001)) ? ndr_pkg::RST_WORD
                   : r.copy_count - (copy_word_i ? 16'h0002 : 16'h0001);
    end

    // Destination tracking; the first byte's bit 0 is the group marker
    if (rx_start_i) begin
      n.da_idx  = 3'h0;
      n.da_done = 1'b0;
      n.phys_ok = 1'b1;
      n.group   = 1'b0;
      n.crc     = ndr_pkg::CRC_INIT;
      n.lda     = {r.wpage, ndr_pkg::RST_BYTE};
    end else if (rx_da_valid_i & ~r.da_done) begin
      if (r.da_idx == 3'h0) begin
        n.group = rx_da_byte_i[0];
      end
      n.phys_ok = r.phys_ok & (rx_da_byte_i == r.station[r.da_idx]);
      n.crc     = crc_byte(r.crc, rx_da_byte_i);
      n.da_idx  = r.da_idx + 3'h1;
      if (r.da_idx == ndr_pkg::DA_LAST_BYTE) begin
        n.da_done  = 1'b1;
        n.hash_idx = n.crc[31:26];
      end
    end

    // Local DMA pointer, page linking against the guard page
    if (rx_byte_i & ~listen_only_mode_i & ~rx_start_i) begin
      if (r.lda[7:0] == 8'hFF) begin
        if (next_pg == r.ring_guard) begin
          n.abort = 1'b1;
        end else begin
          n.lda = {next_pg, ndr_pkg::RST_BYTE};
        end
      end else begin
        n.lda = r.lda + 16'h0001;
      end
    end

    // End of frame: advance the write page or roll back the pointer
    if (frame_end_i & ~rx_start_i & ~listen_only_mode_i) begin
      if (rx_err) begin
        n.lda = {r.wpage, ndr_pkg::RST_BYTE};
      end else if (recognised) begin
        n.wpage = done_pg;
      end
    end

    // Tallies: a read subtracts what it returned; counts stop at TALLY_MAX, dropping later events
    for (int t = 0; t < 3; t++) begin
      if (rd_take && idx == ndr_pkg::IDX_TALLY_BASE + 6'(t)) begin
        n.tally[t] = r.tally[t] - r.rdata[7:0];
      end
      if (tally_inc[t] && n.tally[t] < ndr_pkg::TALLY_MAX) begin
        n.tally[t] = n.tally[t] + 8'h01;
      end
    end

    // Loopback capture keeps the last eight bytes, oldest at the read pointer
    if (lb_valid_i & loopback_mode_i) begin
      n.lb_mem[r.lb_wr] = lb_byte_i;
      n.lb_wr           = r.lb_wr + 3'h1;
      n.lb_rd           = r.lb_wr + 3'h1;
    end else if (rd_take && idx == ndr_pkg::IDX_LOOPBACK_PORT) begin
      n.lb_rd = r.lb_rd + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      r          <= '0;
      r.crc      <= ndr_pkg::CRC_INIT;
      r.tx_len   <= ndr_pkg::RST_WORD;
      r.wpage    <= ndr_pkg::RST_BYTE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest_o     = req & ~r.ack;
  assign avs_readdata_o        = r.rdata;
  assign tx_length_o           = r.tx_len;
  assign local_dma_addr_o      = r.lda;
  assign ring_abort_o          = r.abort;
  assign host_copy_addr_o      = r.copy_addr;
  assign host_copy_count_o     = r.copy_count;
  assign copy_done_o           = (r.copy_count == ndr_pkg::RST_WORD);
  assign addr_match_o          = recognised;
  assign group_indicator_bit_o = r.group;
  assign rx_store_o            = recognised & ~listen_only_mode_i;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Reads are answered in exactly one wait cycle
  bus_answer_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("read not answered after one wait cycle");

  tally_cap_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    r.tally[ndr_pkg::TALLY_LOST] <= ndr_pkg::TALLY_MAX)
    else $error("lost tally above maximum");

  tally_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (rd_take && idx == ndr_pkg::IDX_TALLY_BASE && !frame_end_i && !$past(frame_end_i))
    |=> r.tally[ndr_pkg::TALLY_ALIGN] == 8'h00)
    else $error("alignment tally not cleared by read");

  page_wrap_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (rx_byte_i && !rx_start_i && !listen_only_mode_i && r.lda[7:0] == 8'hFF
     && r.lda[15:8] + 8'h01 == r.ring_last && r.ring_first != r.ring_guard)
    |=> r.lda == {$past(r.ring_first), 8'h00})
    else $error("ring did not wrap to first page");

  guard_abort_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ring_abort_o |-> $stable(r.lda) && r.lda[7:0] == 8'hFF)
    else $error("abort moved the local pointer");

  err_restore_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (frame_end_i && rx_err && !rx_start_i && !listen_only_mode_i)
    |=> local_dma_addr_o == {$past(r.wpage), 8'h00})
    else $error("pointer not restored on receive error");

  copy_word_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (copy_step_i && copy_word_i && !wr_take)
    |=> host_copy_addr_o == $past(host_copy_addr_o) + 16'h0002)
    else $error("copy address did not step by two");

  copy_count_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (copy_step_i && !copy_word_i && !wr_take && host_copy_count_o != 16'h0000)
    |=> host_copy_count_o == $past(host_copy_count_o) - 16'h0001)
    else $error("copy count did not drop by one");

  hash_latch_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (rx_da_valid_i && !rx_start_i && !r.da_done && r.da_idx == ndr_pkg::DA_LAST_BYTE)
    |=> r.da_done && r.hash_idx == r.crc[31:26])
    else $error("hash not latched from final CRC");

  group_bit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (rx_da_valid_i && !rx_start_i && !r.da_done && r.da_idx == 3'h0)
    |=> group_indicator_bit_o == $past(rx_da_byte_i[0]))
    else $error("group marker not taken from first bit");

  store_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    listen_only_mode_i |-> !rx_store_o)
    else $error("frame stored in listen-only mode");

  // Main scenarios
  cov_abort_c:  cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) ring_abort_o);
  cov_tally_c:  cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tally_inc[ndr_pkg::TALLY_CRC] ##[1:20] rd_take);
  cov_group_c:  cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) recognised && r.group);
  cov_lb_c:     cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_take && idx == ndr_pkg::IDX_LOOPBACK_PORT);

endmodule

// ### test/ndr_host_model.sv
// Purpose: Host processor model, the Avalon-MM master of the register bank
// Assumes: One request at a time, raised just after a rising edge
// Notes:   Falling-edge sampling sees what the next rising edge sees
`timescale 1ns/100ps
module ndr_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        avs_waitrequest_i,
  input  wire logic [31:0] avs_readdata_i,
  output logic      [7:0]  avs_address_o,
  output logic             avs_read_o,
  output logic             avs_write_o,
  output logic      [31:0] avs_writedata_o,
  output logic      [3:0]  avs_byteenable_o
);
  // ------------------------------------------------
  // Bus master
  // ------------------------------------------------
  // Idle bus from time zero
  initial begin
    avs_address_o = 8'h00;
    avs_read_o = 1'h0;
    avs_write_o = 1'h0;
    avs_writedata_o = 32'h0000_0000;
    avs_byteenable_o = 4'h1;
  end

  // Request held until waitrequest low; bounded so a hang is reported
  task automatic access(input logic w, input logic [5:0] idx, input logic [7:0] d,
                        output logic [7:0] q, output logic to);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_o <= {idx, 2'h0};
    avs_writedata_o <= {24'h00_0000, d};
    avs_write_o <= w;
    avs_read_o <= ~w;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (avs_waitrequest_i !== 1'h0 && n < 64);
    q = avs_readdata_i[7:0];
    to = (avs_waitrequest_i !== 1'h0);
    @(posedge clk_sys_i);
    avs_write_o <= 1'h0;
    avs_read_o <= 1'h0;
    // Let the accept edge's updates land before the caller looks
    @(negedge clk_sys_i);
  endtask
endmodule

// ### test/testbench.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Event pulses driven at the rising edge, checked at the falling edge
// Notes:   Bit map of ev: st dv rb fe fae crc nb listen loop lv cs cw
`timescale 1ns/100ps
module testbench;
  localparam logic [11:0] ST = 12'h800, RB = 12'h200, FE = 12'h100, FAE = 12'h080, CRC = 12'h040;
  localparam logic [11:0] NB = 12'h020, LV = 12'h004, CS = 12'h002, CW = 12'h001;
  localparam logic [5:0]  TALN = ndr_pkg::IDX_TALLY_BASE;
  localparam logic [5:0]  TCRC = 6'(ndr_pkg::IDX_TALLY_BASE + ndr_pkg::TALLY_CRC);
  localparam logic [5:0]  TLST = 6'(ndr_pkg::IDX_TALLY_BASE + ndr_pkg::TALLY_LOST);
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [11:0] ev = 12'h000;
  logic [7:0]  da_byte = 8'h00;
  logic [7:0]  lb_byte = 8'h00;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [3:0]  ben;
  logic [15:0] tx_len, lda, caddr, ccnt;
  logic        rd_s, wr_s, wait_s, abort, done, match, grp, store;
  int          failures = 0;
  int          n_compared = 0;

  always #10 clk = ~clk;

  ndr_host_model i_host (.clk_sys_i(clk), .avs_waitrequest_i(wait_s), .avs_readdata_i(rdat),
    .avs_address_o(adr), .avs_read_o(rd_s), .avs_write_o(wr_s), .avs_writedata_o(wdat),
    .avs_byteenable_o(ben));

  ndr_regs i_dut (.clk_sys_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_byteenable_i(ben), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_s), .tx_length_o(tx_len), .rx_start_i(ev[11]), .rx_da_valid_i(ev[10]),
    .rx_da_byte_i(da_byte), .rx_byte_i(ev[9]), .frame_end_i(ev[8]), .fae_i(ev[7]), .crc_err_i(ev[6]),
    .no_buffer_i(ev[5]), .listen_only_mode_i(ev[4]), .loopback_mode_i(ev[3]), .lb_valid_i(ev[2]),
    .lb_byte_i(lb_byte), .copy_step_i(ev[1]), .copy_word_i(ev[0]), .local_dma_addr_o(lda),
    .ring_abort_o(abort), .host_copy_addr_o(caddr), .host_copy_count_o(ccnt), .copy_done_o(done),
    .addr_match_o(match), .group_indicator_bit_o(grp), .rx_store_o(store));

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic wrap_up();
    if (failures == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask

  task automatic acc(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [7:0] q);
    logic to;
    i_host.access(w, i, d, q, to);
    if (to) begin
      $display("[FAIL] waitrequest expected 0 seen 1");
      failures++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] q;
    acc(1'h1, i, d, q);
  endtask

  task automatic rdc(input string nm, input logic [5:0] i, input logic [7:0] e);
    logic [7:0] q;
    acc(1'h0, i, 8'h00, q);
    chk(nm, {8'h00, e}, {8'h00, q});
  endtask

  // One-cycle pulse on the masked event bits
  task automatic tick(input logic [11:0] m);
    @(posedge clk);
    ev <= ev | m;
    @(posedge clk);
    ev <= ev & ~m;
    @(negedge clk);
  endtask

  // Frame start then six destination bytes, first byte first
  task automatic frame(input logic [47:0] d);
    tick(ST);
    for (int k = 0; k < 6; k++) begin
      da_byte <= d[8*k +: 8];
      tick(12'h400);
    end
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic s_regs();
    wr(ndr_pkg::IDX_RING_FIRST, 8'h40);
    wr(ndr_pkg::IDX_RING_LAST, 8'h42);
    wr(ndr_pkg::IDX_RING_GUARD, 8'h40);
    wr(ndr_pkg::IDX_RX_WRITE_PAGE, 8'h40);
    wr(ndr_pkg::IDX_TX_LEN_LO, 8'h00);
    wr(ndr_pkg::IDX_TX_LEN_HI, 8'h06);
    chk("tx_length", 16'h0600, tx_len);
    rdc("ring_first", ndr_pkg::IDX_RING_FIRST, 8'h40);
    rdc("tx_len_low", ndr_pkg::IDX_TX_LEN_LO, 8'h00);
    rdc("unmapped", 6'h3F, 8'h00);
  endtask

  task automatic s_copy();
    wr(ndr_pkg::IDX_COPY_START_LO, 8'hFF);
    wr(ndr_pkg::IDX_COPY_START_HI, 8'h12);
    wr(ndr_pkg::IDX_COPY_COUNT_LO, 8'h03);
    wr(ndr_pkg::IDX_COPY_COUNT_HI, 8'h01);
    chk("copy_count", 16'h0103, ccnt);
    tick(CS | CW);
    chk("copy_addr", 16'h1301, caddr);
    chk("copy_count", 16'h0101, ccnt);
    tick(CS);
    chk("copy_addr", 16'h1302, caddr);
    chk("copy_count", 16'h0100, ccnt);
    chk("copy_done", 16'h0000, {15'h0000, done});
    rdc("copy_addr_high", ndr_pkg::IDX_COPY_ADDR_HI, 8'h13);
    rdc("copy_addr_low", ndr_pkg::IDX_COPY_ADDR_LO, 8'h02);
  endtask

  task automatic s_ring();
    int first;
    first = 0;
    tick(ST);
    repeat (3) tick(RB);
    chk("local_dma", 16'h4003, lda);
    tick(FE | CRC);
    chk("local_dma", 16'h4000, lda);
    rdc("local_dma_high", ndr_pkg::IDX_LDA_HI, 8'h40);
    tick(ST);
    // Page 40 links cleanly to 41; page 41 wraps to 40 instead of entering 42, and 40 is the guard
    for (int k = 1; k <= 600 && first == 0; k++) begin
      tick(RB);
      if (abort === 1'h1) first = k;
    end
    chk("abort_window", 16'h0001, 16'(first > 300 && first < 600));
  endtask

  task automatic s_filter();
    logic [7:0] q;
    for (int k = 0; k < 6; k++) wr(6'(ndr_pkg::IDX_STATION_BASE + k), 8'(8'h10 + k));
    rdc("station5", 6'(ndr_pkg::IDX_STATION_BASE + 5), 8'h15);
    acc(1'h0, TCRC, 8'h00, q);
    acc(1'h0, TALN, 8'h00, q);
    frame(48'h1514_1312_1110);
    chk("addr_match", 16'h0001, {15'h0000, match});
    chk("group_bit", 16'h0000, {15'h0000, grp});
    tick(FE | CRC);
    rdc("crc_tally", TCRC, 8'h01);
    rdc("crc_tally", TCRC, 8'h00);
    frame(48'h1514_13FF_1110);
    chk("addr_match", 16'h0000, {15'h0000, match});
    tick(FE | FAE | CRC);
    rdc("align_tally", TALN, 8'h00);
    ev[4] <= 1'h1;
    frame(48'h1514_1312_1110);
    chk("rx_store", 16'h0000, {15'h0000, store});
    tick(FE);
    rdc("lost_tally", TLST, 8'h01);
    ev[4] <= 1'h0;
    repeat (200) begin
      frame(48'h1514_1312_1110);
      tick(FE | NB);
    end
    rdc("lost_tally", TLST, ndr_pkg::TALLY_MAX);
    for (int h = 0; h < 2; h++) begin
      for (int k = 0; k < 8; k++) wr(6'(ndr_pkg::IDX_HASH_BASE + k), h ? 8'h00 : 8'hFF);
      frame(48'h0000_0000_0001);
      chk("group_bit", 16'h0001, {15'h0000, grp});
      chk("group_match", 16'(h == 0), {15'h0000, match});
    end
  endtask

  task automatic s_loop();
    ev[3] <= 1'h1;
    for (int k = 0; k < 8; k++) begin
      lb_byte <= 8'(8'hA0 + k);
      tick(LV);
    end
    for (int k = 0; k < 8; k++) rdc("loopback", ndr_pkg::IDX_LOOPBACK_PORT, 8'(8'hA0 + k));
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    s_regs();
    s_copy();
    s_ring();
    s_filter();
    s_loop();
    wrap_up();
  end
endmodule
